// [hw/uart_scon_defines.svh]
// Register offsets, field positions, reset values and timing counts for the serial port
`ifndef UART_SCON_DEFINES_SVH
`define UART_SCON_DEFINES_SVH

// Special-function addresses
`define SCON_ADDR 8'h98
`define SBUF_ADDR 8'h99

// Control register reset value (bit 6 always reads 1)
`define SCON_RESET 8'h40

// Control register field positions
`define SCON_MODE 3'h7
`define SCON_ONE 3'h6
`define SCON_MCE 3'h5
`define SCON_REN 3'h4
`define SCON_TB8 3'h3
`define SCON_RB8 3'h2
`define SCON_TI 3'h1
`define SCON_RI 3'h0

// Baud timer overflow value (8-bit auto-reload)
`define TMR_TOP 8'hff

// Data bits per frame, less one
`define LAST_DATA_BIT 3'h7

`endif

// [hw/uart_scon_pkg.sv]
// Types shared by the serial port control logic
package uart_scon_pkg;

	// Transmit sequencer states
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_t;

	// Receive sequencer states
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_t;

	// Register byte and bus address
	typedef logic [7:0] sfr_byte_t;

endpackage

// [hw/uart_serial_control.sv]
// Serial port control/status register, data buffer, baud timers and frame engines
//
// How it works
// - Bit 7 selects 8-bit or 9-bit frames
// - Bit 6 reads one, writes ignored
// - 8-bit: filter needs stop bit high
// - 9-bit: filter needs ninth bit high
// - Reception starts only while bit 4 set
// - 9-bit mode sends bit 3 ninth
// - Accepted frame loads stop/ninth into bit 2
// - Transmit flag set at stop bit start
// - Receive flag set at stop sampling
// - Receive flag requests interrupt when enabled
// - Hardware never clears either flag
// - Control register at 0x98, bit access
// - Start, eight data LSB first, ninth bit in 9-bit mode, stop
// - Load only while receive flag clear
// - Bit time is two timer overflows
// - Buffer write sends, read returns receive
`timescale 1ns/1ps
`default_nettype none
`include "uart_scon_defines.svh"

module uart_serial_control (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	// Special-function register bus
	input wire uart_scon_pkg::sfr_byte_t I_SFR_ADDR,
	input wire logic I_SFR_WR,
	input wire logic I_SFR_RD,
	input wire uart_scon_pkg::sfr_byte_t I_SFR_WDATA,
	input wire logic I_SFR_BIT_WR,
	input wire logic [2:0] I_SFR_BIT_SEL,
	input wire logic I_SFR_BIT_VAL,
	output logic [7:0] O_SFR_RDATA,
	output logic O_TX_READY,
	// Baud timer interface
	input wire logic I_T1_TICK,
	input wire uart_scon_pkg::sfr_byte_t I_BAUD_RELOAD,
	// Interrupt controller
	input wire logic I_INT_EN,
	output logic O_IRQ,
	// Serial pins
	input wire logic I_RX,
	output logic O_TX
);
	import uart_scon_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] ctl_r, ctl_nxt; // Control register
	logic [7:0] rdata_r, rdata_nxt; // Read data
	logic irq_r, irq_nxt; // Interrupt request
	logic [7:0] tmr_tx_r, tmr_tx_nxt; // Transmit baud timer
	logic [7:0] tmr_rx_r, tmr_rx_nxt; // Receive copy of baud timer
	logic ph_tx_r, ph_tx_nxt; // Transmit divide-by-two phase
	logic ph_rx_r, ph_rx_nxt; // Receive divide-by-two phase
	logic [7:0] buf_mem_r [2]; // Two-entry transmit buffer
	logic [7:0] buf_mem_nxt [2];
	logic buf_wp_r, buf_wp_nxt; // Buffer write pointer
	logic buf_rp_r, buf_rp_nxt; // Buffer read pointer
	logic [1:0] buf_cnt_r, buf_cnt_nxt; // Buffer fill level
	logic tx_rdy_r, tx_rdy_nxt; // Buffer can accept a write
	tx_state_t tx_st_r, tx_st_nxt; // Transmit sequencer
	logic [7:0] tx_sh_r, tx_sh_nxt; // Transmit shifter
	logic [2:0] tx_bit_r, tx_bit_nxt; // Transmit data bit count
	logic tx_pin_r, tx_pin_nxt; // Transmit pin
	rx_state_t rx_st_r, rx_st_nxt; // Receive sequencer
	logic [7:0] rx_sh_r, rx_sh_nxt; // Receive shifter
	logic [2:0] rx_bit_r, rx_bit_nxt; // Receive data bit count
	logic rx_n9_r, rx_n9_nxt; // Received ninth bit
	logic [7:0] rx_buf_r, rx_buf_nxt; // Receive latch
	logic rx_prev_r; // Last receive pin level
	logic tx_ovf, rx_ovf; // Timer overflows
	logic tx_tick, rx_samp; // Bit boundary and sample point
	logic start_det; // Falling edge on the receive pin
	logic push, pop; // Buffer moves
	logic set_ti, set_ri, load_rb8; // Hardware events
	logic rb8_val; // Value for bit 2 on acceptance
	logic ctl_sel, buf_sel; // Address decode

	assign ctl_sel = (I_SFR_ADDR == `SCON_ADDR);
	assign buf_sel = (I_SFR_ADDR == `SBUF_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// Baud timers

	// Overflow and bit-rate strobes from the two timers
	always_comb begin
		tx_ovf = I_T1_TICK && (tmr_tx_r == `TMR_TOP);
		rx_ovf = I_T1_TICK && (tmr_rx_r == `TMR_TOP);
		tx_tick = tx_ovf && ph_tx_r;
		// Sample the first overflow after the start edge, then every second one
		rx_samp = rx_ovf && !ph_rx_r;
		start_det = (rx_st_r == RX_IDLE) && ctl_r[`SCON_REN] && rx_prev_r && !I_RX;
		tmr_tx_nxt = tmr_tx_r;
		ph_tx_nxt = ph_tx_r;
		tmr_rx_nxt = tmr_rx_r;
		ph_rx_nxt = ph_rx_r;
		if (I_T1_TICK) begin
			tmr_tx_nxt = tx_ovf ? I_BAUD_RELOAD : tmr_tx_r + 8'h01;
			tmr_rx_nxt = rx_ovf ? I_BAUD_RELOAD : tmr_rx_r + 8'h01;
		end
		if (tx_ovf) begin
			ph_tx_nxt = !ph_tx_r;
		end
		if (rx_ovf) begin
			ph_rx_nxt = !ph_rx_r;
		end
		// Start edge forces a receive reload so reception is free of the transmit phase
		if (start_det) begin
			tmr_rx_nxt = I_BAUD_RELOAD;
			ph_rx_nxt = 1'b0;
		end
	end

	// Timer registers
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			tmr_tx_r <= 8'h00;
			tmr_rx_r <= 8'h00;
			ph_tx_r <= 1'b0;
			ph_rx_r <= 1'b0;
			rx_prev_r <= 1'b1;
		end else begin
			tmr_tx_r <= tmr_tx_nxt;
			tmr_rx_r <= tmr_rx_nxt;
			ph_tx_r <= ph_tx_nxt;
			ph_rx_r <= ph_rx_nxt;
			rx_prev_r <= I_RX;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit buffer and sequencer

	// Two entries let software queue the next byte while one is on the wire
	always_comb begin
		// Buffer write queues a byte to send
		push = I_SFR_WR && buf_sel && (buf_cnt_r != 2'h2);
		pop = (tx_st_r == TX_IDLE) && (buf_cnt_r != 2'h0);
		buf_mem_nxt = buf_mem_r;
		buf_wp_nxt = buf_wp_r ^ push;
		buf_rp_nxt = buf_rp_r ^ pop;
		buf_cnt_nxt = buf_cnt_r + {1'b0, push} - {1'b0, pop};
		if (push) begin
			buf_mem_nxt[buf_wp_r] = I_SFR_WDATA;
		end
		// Writes while full are dropped, so the source must watch O_TX_READY
		tx_rdy_nxt = (buf_cnt_nxt != 2'h2);
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_bit_nxt = tx_bit_r;
		tx_pin_nxt = tx_pin_r;
		set_ti = 1'b0;
		case (tx_st_r)
			TX_IDLE: begin
				if (pop) begin
					tx_sh_nxt = buf_mem_r[buf_rp_r];
					tx_pin_nxt = 1'b0;
					tx_st_nxt = TX_START;
				end
			end
			TX_START: begin
				if (tx_tick) begin
					tx_pin_nxt = tx_sh_r[0];
					tx_bit_nxt = 3'h0;
					tx_st_nxt = TX_DATA;
				end
			end
			TX_DATA: begin
				// Shift out least significant bit first
				if (tx_tick) begin
					if (tx_bit_r == `LAST_DATA_BIT) begin
						if (ctl_r[`SCON_MODE]) begin
							// Ninth bit from control bit 3
							tx_pin_nxt = ctl_r[`SCON_TB8];
							tx_st_nxt = TX_NINTH;
						end else begin
							// Flag at start of stop bit
							tx_pin_nxt = 1'b1;
							set_ti = 1'b1;
							tx_st_nxt = TX_STOP;
						end
					end else begin
						tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
						tx_pin_nxt = tx_sh_r[1];
						tx_bit_nxt = tx_bit_r + 3'h1;
					end
				end
			end
			TX_NINTH: begin
				// Flag at start of stop bit
				if (tx_tick) begin
					tx_pin_nxt = 1'b1;
					set_ti = 1'b1;
					tx_st_nxt = TX_STOP;
				end
			end
			TX_STOP: begin
				if (tx_tick) begin
					tx_st_nxt = TX_IDLE;
				end
			end
			default: begin
				tx_pin_nxt = 1'b1;
				tx_st_nxt = TX_IDLE;
			end
		endcase
	end

	// Transmit registers
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			buf_mem_r[0] <= 8'h00;
			buf_mem_r[1] <= 8'h00;
			buf_wp_r <= 1'b0;
			buf_rp_r <= 1'b0;
			buf_cnt_r <= 2'h0;
			tx_rdy_r <= 1'b1;
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 8'h00;
			tx_bit_r <= 3'h0;
			tx_pin_r <= 1'b1;
		end else begin
			buf_mem_r <= buf_mem_nxt;
			buf_wp_r <= buf_wp_nxt;
			buf_rp_r <= buf_rp_nxt;
			buf_cnt_r <= buf_cnt_nxt;
			tx_rdy_r <= tx_rdy_nxt;
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_pin_r <= tx_pin_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive sequencer

	// Bits are sampled near mid-bit, one overflow after the start edge
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_bit_nxt = rx_bit_r;
		rx_n9_nxt = rx_n9_r;
		rx_buf_nxt = rx_buf_r;
		set_ri = 1'b0;
		load_rb8 = 1'b0;
		rb8_val = 1'b0;
		case (rx_st_r)
			RX_IDLE: begin
				if (start_det) begin
					rx_st_nxt = RX_START;
				end
			end
			RX_START: begin
				// A start bit that has gone high by mid-bit was a glitch
				if (rx_samp) begin
					rx_bit_nxt = 3'h0;
					rx_st_nxt = I_RX ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_samp) begin
					rx_sh_nxt = {I_RX, rx_sh_r[7:1]};
					rx_bit_nxt = rx_bit_r + 3'h1;
					if (rx_bit_r == `LAST_DATA_BIT) begin
						rx_st_nxt = ctl_r[`SCON_MODE] ? RX_NINTH : RX_STOP;
					end
				end
			end
			RX_NINTH: begin
				if (rx_samp) begin
					rx_n9_nxt = I_RX;
					rx_st_nxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_samp) begin
					rx_st_nxt = RX_IDLE;
					rb8_val = ctl_r[`SCON_MODE] ? rx_n9_r : I_RX;
					// Filter on stop or ninth bit
					if (!ctl_r[`SCON_RI] && (!ctl_r[`SCON_MCE] || rb8_val)) begin
						set_ri = 1'b1;
						load_rb8 = 1'b1;
						rx_buf_nxt = rx_sh_r;
					end
				end
			end
			default: begin
				rx_st_nxt = RX_IDLE;
			end
		endcase
	end

	// Receive registers
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			rx_st_r <= RX_IDLE;
			rx_sh_r <= 8'h00;
			rx_bit_r <= 3'h0;
			rx_n9_r <= 1'b0;
			rx_buf_r <= 8'h00;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_n9_r <= rx_n9_nxt;
			rx_buf_r <= rx_buf_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register, read port and interrupt

	// Software writes first, hardware events applied on top
	always_comb begin
		ctl_nxt = ctl_r;
		if (I_SFR_WR && ctl_sel) begin
			ctl_nxt = I_SFR_WDATA;
		end else if (I_SFR_BIT_WR && ctl_sel) begin
			ctl_nxt[I_SFR_BIT_SEL] = I_SFR_BIT_VAL;
		end
		ctl_nxt[`SCON_ONE] = 1'b1;
		if (set_ti) begin
			ctl_nxt[`SCON_TI] = 1'b1;
		end
		if (set_ri) begin
			ctl_nxt[`SCON_RI] = 1'b1;
		end
		if (load_rb8) begin
			ctl_nxt[`SCON_RB8] = rb8_val;
		end
		rdata_nxt = rdata_r;
		if (I_SFR_RD) begin
			rdata_nxt = ctl_sel ? ctl_nxt : (buf_sel ? rx_buf_nxt : 8'h00);
		end
		irq_nxt = I_INT_EN && (ctl_nxt[`SCON_TI] || ctl_nxt[`SCON_RI]);
	end

	// Control registers
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			ctl_r <= `SCON_RESET;
			rdata_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			ctl_r <= ctl_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign O_SFR_RDATA = rdata_r;
	assign O_IRQ = irq_r;
	assign O_TX = tx_pin_r;
	assign O_TX_READY = tx_rdy_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	a_bit6_one: assert property (ctl_r[6])
		else $error("control bit 6 not one");
	a_flag_sticky: assert property ($fell(ctl_r[1]) |-> $past(I_SFR_WR || I_SFR_BIT_WR))
		else $error("transmit flag cleared without a write");
	a_ri_set_wins: assert property (set_ri |=> ctl_r[0])
		else $error("receive flag set lost");
	a_ti_at_stop: assert property (set_ti |=> tx_st_r == TX_STOP && O_TX)
		else $error("transmit flag not at stop bit");
	a_rx_disabled: assert property (!ctl_r[4] && rx_st_r == RX_IDLE |=> rx_st_r == RX_IDLE)
		else $error("reception started while disabled");
	a_filter_hold: assert property ($rose(ctl_r[0]) && !$past(I_SFR_WR || I_SFR_BIT_WR) |-> !ctl_r[5] || ctl_r[2])
		else $error("filtered frame accepted");
	a_no_overwrite: assert property (ctl_r[0] |=> $stable(rx_buf_r))
		else $error("receive latch changed while flag set");
	a_irq_follows: assert property (1'b1 |=> O_IRQ == ($past(I_INT_EN) && (ctl_r[1] || ctl_r[0])))
		else $error("interrupt request mismatch");
	a_ninth_sent: assert property (tx_st_r == TX_DATA && tx_st_nxt == TX_NINTH |=> O_TX == $past(ctl_r[3]))
		else $error("ninth bit wrong");

	c_tx_frame: cover property (set_ti);
	c_rx_accept: cover property (set_ri && ctl_r[7]);
	c_rx_filtered: cover property (rx_st_r == RX_STOP && rx_samp && !set_ri);
	c_buf_full: cover property (!O_TX_READY);

endmodule // uart_serial_control

`default_nettype wire

// [verification/uart_far_end.sv]
// Remote serial device model: drives the receive pin, decodes the transmit pin
`timescale 1ns/1ps
`default_nettype none

module uart_far_end #(
	parameter int BIT_CYC = 8
) (
	// Clock and serial pins
	input wire logic i_clk,
	input wire logic i_tx,
	output logic o_rx
);
	logic smp [0:99]; // Transmit pin, one sample a cycle

	// Line idles high
	initial o_rx = 1'b1;

	task automatic send(input logic [7:0] d, input logic nine, input logic ninth,
		input logic stp);
		logic [10:0] f;
		f = nine ? {stp, ninth, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int k = 0; k < (nine ? 11 : 10); k++) begin
			o_rx = f[k];
			repeat (BIT_CYC) @(posedge i_clk);
			#1;
		end
		// One idle cycle so back-to-back frames never reassign in one step
		o_rx = 1'b1;
		@(posedge i_clk);
		#1;
	endtask

	// frame decode, phase taken from first bit edge
	task automatic get(input logic nine, output logic [9:0] w);
		int t;
		int l;
		t = 0;
		l = 0;
		w = 10'h3ff;
		while (i_tx !== 1'b0 && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		// The first start bit may be short, so the phase is measured
		for (int k = 0; k < 100; k++) begin
			smp[k] = i_tx;
			if (l == 0 && k > 0 && smp[k] !== smp[k-1]) begin
				l = ((k - 1) % BIT_CYC) + 1;
			end
			if (l > 0 && k == l + BIT_CYC * (nine ? 10 : 9) - 4) begin
				break;
			end
			@(negedge i_clk);
		end
		for (int m = 0; m < (nine ? 10 : 9); m++) begin
			w[m] = smp[l + BIT_CYC * m + 4];
		end
		if (t >= 400) begin
			w = 10'hx;
		end
		@(posedge i_clk);
		#1;
	endtask
endmodule // uart_far_end

`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none

module tb;
	import uart_scon_pkg::*;
	// Design-side signals
	logic clk;
	logic rst_n;
	sfr_byte_t addr;
	logic wr;
	logic rd;
	sfr_byte_t wdata;
	logic bwr;
	logic [2:0] bsel;
	logic bval;
	logic [7:0] rdata;
	logic tx_rdy;
	logic int_en;
	logic irq;
	logic rx;
	logic tx;
	// Reference model state
	int error_cnt;
	int n_tests;
	int mctl;
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	logic [7:0] v;
	logic [7:0] d;
	logic [9:0] w;

	// Timer ticks every cycle, reload gives 4-tick overflow, 8-cycle bits
	uart_serial_control uart_serial_control_i (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
		.I_SFR_BIT_WR(bwr), .I_SFR_BIT_SEL(bsel), .I_SFR_BIT_VAL(bval),
		.O_SFR_RDATA(rdata), .O_TX_READY(tx_rdy), .I_T1_TICK(1'b1),
		.I_BAUD_RELOAD(8'hfc), .I_INT_EN(int_en), .O_IRQ(irq), .I_RX(rx), .O_TX(tx));
	uart_far_end uart_far_end_i (.i_clk(clk), .i_tx(tx), .o_rx(rx));

	// Verdict and end of run
	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Byte comparison
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Serial frame comparison
	task automatic chk_frame(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bus tasks start and end just after a rising edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
		addr = a;
		wdata = dv;
		wr = 1'b1;
		@(posedge clk);
		#1 wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1 rd = 1'b0;
		q = rdata;
		@(posedge clk);
		#1;
	endtask

	task automatic bit_wr(input logic [2:0] s, input logic b);
		addr = 8'h98;
		bsel = s;
		bval = b;
		bwr = 1'b1;
		@(posedge clk);
		#1 bwr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	// Free-running clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog, far beyond the expected few thousand cycles
	initial begin
		#60000;
		error_cnt++;
		end_sim();
	end

	// Main sequence
	initial begin
		{rst_n, addr, wr, rd, wdata, bwr, bsel, bval, int_en} = '0;
		d = 8'($urandom(32'h3e4a));
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		rd_reg(8'h98, v);
		chk_reg(v, 8'h40);
		// Idle line and an empty transmit buffer after reset
		chk_reg({6'h0, tx_rdy, tx}, 8'h03);
		rd_reg(8'h9a, v);
		chk_reg(v, 8'h00);
		// Software-set flag drives the gated request
		int_en = 1'b1;
		wr_reg(8'h98, 8'h02);
		chk_reg({7'h0, irq}, 8'h01);
		rd_reg(8'h98, v);
		chk_reg(v, 8'h42);
		bit_wr(3'h6, 1'b0);
		bit_wr(3'h1, 1'b0);
		bit_wr(3'h4, 1'b1);
		rd_reg(8'h98, v);
		chk_reg(v, 8'h50);
		// Every mode, filter and ninth/stop combination
		for (int c = 0; c < 8; c++) begin
			mctl = {24'h0, c[2], 1'b1, c[1], 5'h10};
			wr_reg(8'h98, mctl[7:0]);
			d = 8'($urandom);
			uart_far_end_i.send(d, c[2], c[0], c[2] | c[0]);
			if (!c[1] || c[0]) begin
				mctl = mctl | 1 | (c[0] << 2);
				rxq.push_back(d);
			end
			rd_reg(8'h98, v);
			chk_reg(v, mctl[7:0]);
			chk_reg({7'h0, irq}, {7'h0, mctl[0]});
			// A dropped frame leaves the latch at the last accepted byte
			rd_reg(8'h99, v);
			chk_reg(v, rxq[$]);
			wr_reg(8'h98, 8'h00);
		end
		// Second frame while the flag is still up is dropped
		wr_reg(8'h98, 8'h10);
		d = 8'($urandom);
		uart_far_end_i.send(d, 1'b0, 1'b0, 1'b1);
		uart_far_end_i.send(~d, 1'b0, 1'b0, 1'b0);
		rd_reg(8'h98, v);
		chk_reg(v, 8'h55);
		rd_reg(8'h99, v);
		chk_reg(v, d);
		wr_reg(8'h98, 8'h00);
		uart_far_end_i.send(8'ha5, 1'b0, 1'b0, 1'b1);
		rd_reg(8'h98, v);
		chk_reg(v, 8'h40);
		// Fill the transmit buffer until it refuses, decoding in parallel
		for (int c = 0; c < 3; c++) begin
			mctl = {24'h0, c != 0, 3'b100, c == 2, 3'b000};
			// Gate the request off in some passes to see the enable work
			int_en = (c == 1);
			wr_reg(8'h98, mctl[7:0]);
			txq.delete();
			for (int k = 0; k < 3; k++) begin
				d = 8'($urandom);
				txq.push_back(d);
			end
			fork
				for (int k = 0; k < 3; k++) begin
					uart_far_end_i.get(mctl[7], w);
					chk_frame(w, {1'b1, mctl[7] ? mctl[3] : 1'b1, txq[k]});
				end
				begin
					for (int k = 0; k < 3; k++) wr_reg(8'h99, txq[k]);
					chk_reg({7'h0, tx_rdy}, 8'h00);
					// Refused while full; a stray frame would upset the next pass
					wr_reg(8'h99, ~txq[2]);
				end
			join
			rd_reg(8'h98, v);
			chk_reg(v, mctl[7:0] | 8'h02);
			chk_reg({7'h0, irq}, {7'h0, int_en});
			wr_reg(8'h98, 8'h00);
		end
		end_sim();
	end
endmodule // tb

`default_nettype wire
